// >>> bench/rmw_host.sv
/* rmw_host: behavioural host polling interrupt endpoint 1.
   Assumes tb pulses go once per poll and sets give_ack. */
`timescale 1ns/1ns
`default_nettype none
module rmw_host (
    input wire logic clk,
    input wire logic go,
    input wire logic give_ack,
    input wire logic report_valid,
    output logic in_token_ep1,
    output logic ack_ep1
);
    // one token per poll; ack only once data is queued, as a real host would
    always begin
        in_token_ep1 = 1'b0;
        ack_ep1 = 1'b0;
        @(posedge clk iff go);
        #1 in_token_ep1 = 1'b1;
        @(posedge clk);
        #1 in_token_ep1 = 1'b0;
        @(posedge clk);
        if (give_ack && report_valid) begin
            #1 ack_ep1 = 1'b1;
            @(posedge clk);
            #1;
        end
    end
endmodule
`default_nettype wire

// >>> bench/rmw_monitor.sv
/* rmw_monitor: port assertions for rmw_core.
   Assumes a bind from tb; clk and rst_n are the core's own. */
`timescale 1ns/1ns
`default_nettype none
module rmw_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_token_ep1,
    input wire logic ack_ep1,
    input wire logic bus_suspend,
    input wire logic bus_activity,
    input wire logic [7:0] button_pin,
    input wire logic [1:0] function_sel,
    input wire logic wake_poll_enable,
    input wire logic report_valid,
    input wire logic suspended,
    input wire logic remote_wakeup,
    input wire logic pot_discharge,
    input wire logic remote_wake_capable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // host ack that really closes a queued snapshot
    sequence ack_s; ack_ep1 && report_valid && !in_token_ep1; endsequence
    sequence mouse2_s; (function_sel == rmw_pkg::RMW_FN_MOUSE) [*2]; endsequence
    token_snap_a: assert property (in_token_ep1 |=> report_valid)
        else $error("token gave no snapshot");
    snap_cause_a: assert property ($rose(report_valid) |-> $past(in_token_ep1))
        else $error("snapshot without token");
    snap_hold_a: assert property (report_valid && !ack_ep1 |=> report_valid)
        else $error("snapshot dropped before ack");
    ack_clear_a: assert property (ack_s |=> !report_valid)
        else $error("ack did not close snapshot");
    suspend_entry_a: assert property (bus_suspend && !bus_activity && (&button_pin) |=> suspended)
        else $error("suspend not entered");
    resume_cause_a: assert property (suspended && !bus_suspend && (bus_activity || !(&button_pin))
        |=> !suspended)
        else $error("no resume");
    wake_gate_a: assert property (remote_wakeup |-> $past(suspended) && $past(wake_poll_enable))
        else $error("wakeup outside enabled suspend");
    wake_exit_a: assert property (remote_wakeup |-> !suspended)
        else $error("still suspended after wakeup");
    cap_follow_a: assert property (wake_poll_enable [*2] |-> remote_wake_capable)
        else $error("wake capability not shown");
    mouse_pot_a: assert property (mouse2_s |-> !pot_discharge)
        else $error("pot timer active in mouse mode");
endmodule
`default_nettype wire

// >>> bench/tb.sv
/* tb: self-checking bench for rmw_core with the host model.
   Assumes STEP_CYC shortened to STEP; inputs move 1 ns after rise. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int STEP = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] ph = 6'h00;
    logic [1:0] pos [3] = '{2'h0, 2'h0, 2'h0};
    logic [7:0] button_pin = 8'hFF;
    logic [1:0] roller_pairs = 2'h3;
    logic [1:0] function_sel = 2'h0;
    logic wake_poll_enable = 1'b0;
    logic [2:0] wake_poll_interval = 3'h0;
    logic bus_suspend = 1'b0;
    logic bus_activity = 1'b0;
    logic go = 1'b0;
    logic give_ack = 1'b1;
    logic in_token_ep1, ack_ep1, report_valid, suspended, remote_wakeup;
    logic pot_discharge, remote_wake_capable;
    rmw_pkg::rmw_report_t report;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int hi = 0;
    always #5 clk = ~clk;
    rmw_core #(.STEP_CYC(STEP)) u_rmw_core (.clk(clk), .rst_n(rst_n),
        .x_roller_phase_a(ph[1]), .x_roller_phase_b(ph[0]),
        .y_roller_phase_a(ph[3]), .y_roller_phase_b(ph[2]),
        .z_roller_phase_a(ph[5]), .z_roller_phase_b(ph[4]),
        .button_pin(button_pin), .roller_pairs(roller_pairs), .function_sel(function_sel),
        .wake_poll_enable(wake_poll_enable), .wake_poll_interval(wake_poll_interval),
        .in_token_ep1(in_token_ep1), .ack_ep1(ack_ep1), .bus_suspend(bus_suspend),
        .bus_activity(bus_activity), .report(report), .report_valid(report_valid),
        .suspended(suspended), .remote_wakeup(remote_wakeup), .pot_discharge(pot_discharge),
        .remote_wake_capable(remote_wake_capable));
    rmw_host u_rmw_host (.clk(clk), .go(go), .give_ack(give_ack),
        .report_valid(report_valid), .in_token_ep1(in_token_ep1), .ack_ep1(ack_ep1));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // gray stepping: +1 walks 00,01,11,10 as {a,b}; each step given 4 cycles to sync
    task automatic move(input int p, input int n);
        for (int k = 0; k < (n < 0 ? -n : n); k++) begin
            pos[p] = pos[p] + (n < 0 ? 2'h3 : 2'h1);
            ph[2*p +: 2] = {pos[p][1], ^pos[p]};
            tick(4);
        end
    endtask
    task automatic poll(input logic ack);
        give_ack = ack;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(6);
    endtask
    task automatic wake(input logic en, input logic [2:0] code, input logic mv);
        int lat;
        int lo;
        lat = 0;
        lo = (int'(code) + 1) * STEP;
        wake_poll_enable = en;
        wake_poll_interval = code;
        bus_suspend = 1'b1;
        tick(1);
        bus_suspend = 1'b0;
        check("suspended", 8'(suspended), 8'h01);
        if (mv) move(0, 1);
        for (int k = 5; k < 300; k++) begin
            if (remote_wakeup === 1'b1) lat = k;
            tick(1);
        end
        check("wake", 8'(lat >= lo && lat <= lo + 4), 8'(en && mv));
        bus_activity = 1'b1;
        tick(1);
        bus_activity = 1'b0;
        check("resume", 8'(suspended), 8'h00);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard: whole run needs well under this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        tick(10);
        rst_n = 1'b1;
        check("valid", 8'(report_valid), 8'h00);
        move(0, 5);
        move(1, -3);
        move(2, 2);
        button_pin = 8'hFE;
        poll(1);
        check("val0", report.val0, 8'h05);
        check("val1", report.val1, 8'hFD);
        check("val2", report.val2, 8'h02);
        check("buttons", report.buttons, 8'h01);
        button_pin = 8'hFF;
        poll(1);
        check("cleared", report.val0, 8'h00);
        move(0, 1);
        poll(0);
        move(0, 1);
        poll(1);
        check("kept", report.val0, 8'h02);
        ph[1:0] = ~ph[1:0];
        pos[0] = pos[0] + 2'h2;
        tick(4);
        poll(1);
        check("double", report.val0, 8'h00);
        move(0, 130);
        poll(1);
        check("sat_hi", report.val0, 8'h7F);
        move(0, -130);
        poll(1);
        check("sat_lo", report.val0, 8'h80);
        for (int rp = 0; rp < 4; rp++) begin
            roller_pairs = 2'(rp);
            move(0, 1);
            move(1, 1);
            move(2, 1);
            poll(1);
            check("x_en", report.val0, 8'(rp > 0));
            check("y_en", report.val1, 8'(rp > 1));
            check("z_en", report.val2, 8'(rp > 2));
        end
        wake(1'b1, 3'h0, 1'b0);
        wake(1'b1, 3'h0, 1'b1);
        wake(1'b1, 3'h6, 1'b1);
        wake(1'b0, 3'h0, 1'b1);
        bus_suspend = 1'b1;
        tick(1);
        bus_suspend = 1'b0;
        button_pin = 8'h7F;
        tick(1);
        check("btn_resume", 8'(suspended), 8'h00);
        button_pin = 8'hFF;
        // joystick: x pot node held low after a full discharge pulse
        function_sel = 2'h2;
        ph = 6'h00;
        tick(1);
        while (pot_discharge === 1'b1) tick(1);
        while (pot_discharge !== 1'b1) tick(1);
        while (pot_discharge === 1'b1) begin
            hi++;
            tick(1);
        end
        check("discharge", 8'(hi), 8'h10);
        tick(5);
        ph[1] = 1'b1;
        tick(4);
        poll(1);
        check("joy_fmt", 8'(report.format), 8'h02);
        check("pot_x", report.val0, 8'h07); // five low cycles plus two sync stages
        function_sel = 2'h3;
        poll(1);
        check("pad_fmt", 8'(report.format), 8'h03);
        check("pad_val", report.val0, 8'h01);
        summarize();
    end
endmodule
bind rmw_core rmw_monitor u_rmw_monitor (.clk(clk), .rst_n(rst_n),
    .in_token_ep1(in_token_ep1), .ack_ep1(ack_ep1), .bus_suspend(bus_suspend),
    .bus_activity(bus_activity), .button_pin(button_pin), .function_sel(function_sel),
    .wake_poll_enable(wake_poll_enable), .report_valid(report_valid),
    .suspended(suspended), .remote_wakeup(remote_wakeup), .pot_discharge(pot_discharge),
    .remote_wake_capable(remote_wake_capable));
`default_nettype wire

// >>> logic/rmw_core.sv
/*
 * rmw_core: motion sensing, report snapshot and suspend wake polling.
 * Assumes USB protocol logic outside supplies in_token_ep1, ack_ep1, suspend
 * detect and bus activity as one-cycle pulses or levels synchronous to clk.
 */
// Summary of operation
// R1: a pair counts only when the roller-count field assigns it as roller.
// R2: three signed 8-bit movement counters, one per input pair.
// R3: phase order 00,01,11,10 counts up.
// R4: phase order 00,10,11,01 counts down.
// R5: each valid step changes the counter by exactly one.
// R6: an IN token on endpoint 1 snapshots counters into a queued report.
// R7: counters clear only after the host acknowledges that report.
// R8: mouse routes motion inputs to decoders, joystick to pulse timers.
// R9: report layout follows the selected function.
// R10: joystick measures the RC-set pulse width and reports it.
// R11: buttons have pull-ups: low pin means pressed.
// R12: enter suspend when the bus suspend condition is detected.
// R13: leave suspend on bus activity or any pressed button.
// R14: while suspended a timer periodically samples and compares motion inputs.
// R15: a changed poll raises remote wakeup.
// R16: polling gated by wake enable, spacing set by wake interval.
// R17: advertise remote wakeup capability as a descriptor attribute.
// R18: roller-count field: 00 none, 01 x, 10 x and y, 11 all.
// R19: function field: 00 mouse, 10 joystick, 11 gamepad, 01 reserved.
// R20: wake interval code n means 15 ms times n plus one; 111 reserved.
// R21: both bits toggling is ignored; inputs synchronised before decoding.
// R22: counters saturate at signed 8-bit limits.
`timescale 1ns/1ns
`default_nettype none
module rmw_core #(
    parameter int NUM_PAIRS = 3,
    parameter int STEP_CYC = rmw_pkg::RMW_WAKE_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic x_roller_phase_a,
    input wire logic x_roller_phase_b,
    input wire logic y_roller_phase_a,
    input wire logic y_roller_phase_b,
    input wire logic z_roller_phase_a,
    input wire logic z_roller_phase_b,
    input wire logic [7:0] button_pin,
    input wire logic [1:0] roller_pairs,
    input wire logic [1:0] function_sel,
    input wire logic wake_poll_enable,
    input wire logic [2:0] wake_poll_interval,
    input wire logic in_token_ep1,
    input wire logic ack_ep1,
    input wire logic bus_suspend,
    input wire logic bus_activity,
    output rmw_pkg::rmw_report_t report,
    output logic report_valid,
    output logic suspended,
    output logic remote_wakeup,
    output logic pot_discharge,
    output logic remote_wake_capable
);
    localparam int NP = NUM_PAIRS; // ports carry three pairs; fewer may be decoded
    logic [5:0] raw_in;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [NP-1:0] pair_en;
    logic [NP-1:0] pot_done;
    logic [7:0] count [NP];
    logic [7:0] pot_width [NP];
    logic [7:0] pot_run [NP];
    logic pot_phase;
    logic clear_cnt;
    logic mouse_mode;
    logic joy_mode;
    logic [7:0] pressed;
    logic [5:0] poll_last;
    logic [31:0] poll_timer;
    logic [31:0] poll_limit;
    rmw_pkg::rmw_pw_t pw_state;
    logic [NP-1:0] pair_moved;
    logic resume_req;
    logic poll_due;
    logic wake_fire;

    assign raw_in = {z_roller_phase_b, z_roller_phase_a, y_roller_phase_b,
                     y_roller_phase_a, x_roller_phase_b, x_roller_phase_a};
    assign mouse_mode = (function_sel == rmw_pkg::RMW_FN_MOUSE); // [R19]
    assign joy_mode = (function_sel == rmw_pkg::RMW_FN_JOY); // [R19]
    // pull-ups mean an idle pin reads high; invert so 1 = pressed
    assign pressed = ~button_pin; // [R11]
    // clear only when the acknowledged report is the one still queued
    assign clear_cnt = ack_ep1 && report_valid; // [R7]
    // interval code 0..6 -> (code+1) steps; reserved code clamps to longest
    assign poll_limit = (wake_poll_interval > rmw_pkg::RMW_WAKE_CODE_MAX) ?
        32'(STEP_CYC) * 32'(int'(rmw_pkg::RMW_WAKE_CODE_MAX) + 1) :
        32'(STEP_CYC) * (32'(wake_poll_interval) + 32'h0000_0001); // [R20] [R16]

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1; // [R21]
        end
    end

    // pair enable from the roller-count field, only in mouse function
    generate
        for (genvar i = 0; i < NP; i++) begin : g_pair
            assign pair_en[i] = mouse_mode && (roller_pairs > 2'(i)); // [R1] [R18] [R8]
            rmw_quad u_quad (
                .clk(clk),
                .rst_n(rst_n),
                .enable(pair_en[i]),
                .phase('{a: sync2[2*i], b: sync2[2*i+1]}),
                .clear(clear_cnt),
                .count(count[i])
            ); // [R2]
            // suspend poll: has this pair moved since the last reference
            assign pair_moved[i] = (sync2[2*i +: 2] != poll_last[2*i +: 2]); // [R14]
            // joystick: time how long the RC node stays low after release
            assign pot_done[i] = sync2[2*i];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pot_run[i] <= rmw_pkg::RMW_POT_RST;
                    pot_width[i] <= rmw_pkg::RMW_POT_RST;
                end else if (!joy_mode || pot_phase) begin
                    pot_run[i] <= rmw_pkg::RMW_POT_RST;
                end else if (!pot_done[i] && pot_run[i] != 8'hFF) begin
                    pot_run[i] <= pot_run[i] + 8'h01; // [R10]
                end else if (pot_done[i] && pot_run[i] != rmw_pkg::RMW_POT_RST) begin
                    pot_width[i] <= pot_run[i]; // [R10]
                    pot_run[i] <= rmw_pkg::RMW_POT_RST;
                end
            end
        end
    endgenerate

    // discharge pulse restarts each measurement; 16 cycles of every 512, alternating with a 496-cycle window
    logic [8:0] pot_cyc;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pot_cyc <= 9'h000;
            pot_phase <= 1'b0;
            pot_discharge <= 1'b0;
        end else begin
            pot_cyc <= pot_cyc + 9'h001;
            pot_phase <= joy_mode && (pot_cyc[8:4] == 5'h00);
            pot_discharge <= joy_mode && (pot_cyc[8:4] == 5'h00); // [R10] [R8]
        end
    end

    // snapshot on each IN token; layout follows function
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            report <= '0;
        end else if (in_token_ep1) begin
            report.format <= function_sel; // [R9]
            report.buttons <= pressed; // [R11]
            if (joy_mode) begin
                report.val0 <= pot_width[0]; // [R9] [R10]
                report.val1 <= pot_width[1];
                report.val2 <= pot_width[2];
            end else if (mouse_mode) begin
                report.val0 <= count[0]; // [R6]
                report.val1 <= count[1];
                report.val2 <= count[2];
            end else begin
                report.val0 <= {2'b00, sync2}; // gamepad: synchronised inputs (sync2) as buttons
                report.val1 <= 8'h00;
                report.val2 <= 8'h00;
            end
        end
    end

    // queued until acknowledged; a retried token re-snapshots
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            report_valid <= 1'b0;
        end else if (in_token_ep1) begin
            report_valid <= 1'b1; // [R6]
        end else if (ack_ep1) begin
            report_valid <= 1'b0; // [R7]
        end
    end

    // suspend exits: bus traffic or a press wins, even in the poll cycle,
    // so a one-cycle activity pulse is never lost
    assign resume_req = bus_activity || (pressed != 8'h00); // [R13]
    // the timer ends one edge before it would reach the programmed spacing
    assign poll_due = wake_poll_enable && (poll_timer + 32'h0000_0001 >= poll_limit); // [R16]
    // a poll that finds motion wakes the host, only while polling stays enabled
    assign wake_fire = (pw_state == rmw_pkg::RMW_PW_POLL) && !resume_req && wake_poll_enable
        && (pair_moved != '0); // [R15] [R16]

    // power state: run, suspended, momentary poll
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pw_state <= rmw_pkg::RMW_PW_RUN;
        end else begin
            case (pw_state)
                rmw_pkg::RMW_PW_RUN: begin
                    if (bus_suspend) begin
                        pw_state <= rmw_pkg::RMW_PW_SUSP; // [R12]
                    end
                end
                rmw_pkg::RMW_PW_SUSP: begin
                    if (resume_req) begin
                        pw_state <= rmw_pkg::RMW_PW_RUN; // [R13]
                    end else if (poll_due) begin
                        pw_state <= rmw_pkg::RMW_PW_POLL; // [R14] [R16]
                    end
                end
                rmw_pkg::RMW_PW_POLL: begin
                    if (resume_req || wake_fire) begin
                        pw_state <= rmw_pkg::RMW_PW_RUN; // [R13] [R15]
                    end else begin
                        pw_state <= rmw_pkg::RMW_PW_SUSP;
                    end
                end
                default: begin
                    pw_state <= rmw_pkg::RMW_PW_RUN;
                end
            endcase
        end
    end

    // suspended is its own flop so the output needs no decode of the state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            suspended <= 1'b0;
        end else if (pw_state == rmw_pkg::RMW_PW_RUN) begin
            suspended <= bus_suspend; // [R12]
        end else if (resume_req || wake_fire) begin
            suspended <= 1'b0; // [R13] [R15]
        end
    end

    // wake request is a single-cycle pulse per changed poll
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_wakeup <= 1'b0;
        end else begin
            remote_wakeup <= wake_fire; // [R15]
        end
    end

    // poll spacing counter runs only while quietly suspended with polling on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            poll_timer <= 32'h0000_0000;
        end else if (pw_state != rmw_pkg::RMW_PW_SUSP || !wake_poll_enable || poll_due) begin
            poll_timer <= 32'h0000_0000; // [R16]
        end else begin
            poll_timer <= poll_timer + 32'h0000_0001; // [R14]
        end
    end

    // reference for the next poll: taken on entry and refreshed at every poll
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            poll_last <= 6'h00;
        end else if ((pw_state == rmw_pkg::RMW_PW_RUN && bus_suspend) ||
                     pw_state == rmw_pkg::RMW_PW_POLL) begin
            poll_last <= sync2; // [R14]
        end
    end

    // capability bit for the configuration descriptor attributes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_wake_capable <= 1'b0;
        end else begin
            remote_wake_capable <= wake_poll_enable; // [R17]
        end
    end
endmodule
`default_nettype wire

// >>> logic/rmw_pkg.sv
/*
 * rmw_pkg: shared constants and types for the roller motion and wake block.
 * Assumes a single system clock given to rmw_core at RMW_CLK_HZ.
 */
`default_nettype none
package rmw_pkg;
    localparam int RMW_CLK_HZ = 100000000;
    // wake interval: 15 ms per code step, code 0 = 15 ms
    localparam int RMW_WAKE_STEP_MS = 15;
    localparam int RMW_WAKE_STEP_CYC = RMW_CLK_HZ / 1000 * RMW_WAKE_STEP_MS;
    localparam logic [2:0] RMW_WAKE_CODE_MAX = 3'h6;
    localparam logic [7:0] RMW_CNT_RST = 8'h00;
    localparam logic signed [7:0] RMW_CNT_MAX = 8'sh7F;
    localparam logic signed [7:0] RMW_CNT_MIN = -8'sh80;
    localparam logic [1:0] RMW_PAIRS_NONE = 2'h0;
    localparam logic [7:0] RMW_POT_RST = 8'h00;

    typedef enum logic [1:0] {
        RMW_FN_MOUSE = 2'b00,
        RMW_FN_RSVD = 2'b01,
        RMW_FN_JOY = 2'b10,
        RMW_FN_PAD = 2'b11
    } rmw_func_t;

    typedef enum logic [1:0] {
        RMW_PW_RUN = 2'b00,
        RMW_PW_SUSP = 2'b01,
        RMW_PW_POLL = 2'b10
    } rmw_pw_t;

    // one pair of quadrature phases
    typedef struct packed {
        logic a;
        logic b;
    } rmw_pair_t;

    // report sent on the interrupt endpoint
    typedef struct packed {
        logic [1:0] format;
        logic [7:0] buttons;
        logic [7:0] val0;
        logic [7:0] val1;
        logic [7:0] val2;
    } rmw_report_t;
endpackage
`default_nettype wire

// >>> logic/rmw_quad.sv
/*
 * rmw_quad: one quadrature decoder with a saturating signed 8-bit counter.
 * Assumes phase inputs are already synchronised and clear is a one-cycle pulse.
 */
`timescale 1ns/1ns
`default_nettype none
module rmw_quad (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire rmw_pkg::rmw_pair_t phase,
    input wire logic clear,
    output logic [7:0] count
);
    rmw_pkg::rmw_pair_t prev;
    logic step_up;
    logic step_dn;
    logic signed [7:0] scount;

    assign scount = count;

    // forward order 00,01,11,10 ; reverse 00,10,11,01; double toggles ignored
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        case ({prev.a, prev.b, phase.a, phase.b})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: step_up = 1'b1; // [R3]
            4'b0010, 4'b1011, 4'b1101, 4'b0100: step_dn = 1'b1; // [R4] [R21]
            default: begin
                step_up = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= '0;
        end else begin
            prev <= phase;
        end
    end

    // clear beats a simultaneous step: that step is dropped and appears in neither report
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= rmw_pkg::RMW_CNT_RST;
        end else if (clear) begin
            count <= rmw_pkg::RMW_CNT_RST; // [R7]
        end else if (enable && step_up && scount != rmw_pkg::RMW_CNT_MAX) begin
            count <= count + 8'h01; // [R5] [R22]
        end else if (enable && step_dn && scount != rmw_pkg::RMW_CNT_MIN) begin
            count <= count - 8'h01; // [R5] [R22]
        end
    end
endmodule
`default_nettype wire
